// file: design/fwlsp_pkg.sv
// Overview of operation
// - write-allow opcode sets write latch flag
// - host sends write-allow before each modifying command
// - write-forbid opcode clears write latch flag
// - latch cleared at reset and command completion
// - latch clear blocks program, erase, and status write unless volatile-enabled
// - volatile-enable makes next status write volatile
// - status read answered even while busy
// - 05H gives low byte, 35H high byte
// - status shifted out msb first, host ends read
// - upper byte layout from erase-paused to guard
// - busy flag set during program, erase, write
// - protect range bits guard array, writable unless locked
// - chip erase only with no protection set (here only the range bits are checked; the invert bit is ignored)
// - guard bits decode software, pin, power, permanent
// - power cycle clears power-cycle guard setting
// - quad enable bit repurposes protect and pause pins (here it only drives o_quad_lines; pin guard mode still reads i_protect_pin)
// - security lock bits set once, cleared only by reset
// - protect invert bit combines with range bits
// - suspend sets program- or erase-paused flag, resume clears both
// - host polls busy flag before new command
package fwlsp_pkg;
  localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
  localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OP_VOLATILE_ALLOW = 8'h50;
  localparam logic [7:0] OP_STATUS_READ_LO = 8'h05;
  localparam logic [7:0] OP_STATUS_READ_HI = 8'h35;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_WRITE_HI = 8'h31;
  localparam logic [7:0] OP_CONFIG_WRITE = 8'h11;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'h81;
  localparam logic [7:0] OP_SMALL_CLEAR = 8'h20;
  localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
  localparam logic [7:0] OP_BLOCK_CLEAR = 8'hD8;
  localparam logic [7:0] OP_CHIP_CLEAR_A = 8'h60;
  localparam logic [7:0] OP_CHIP_CLEAR_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h73;
  localparam logic [7:0] OP_RESET = 8'h99;
  // status bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_LATCH = 1;
  localparam int BIT_RANGE_LO = 2;
  localparam int BIT_GUARD_LO = 7;
  localparam int BIT_GUARD_HI = 8;
  localparam int BIT_QUAD = 9;
  localparam int BIT_PROG_PAUSE = 10;
  localparam int BIT_LOCK_LO = 11;
  localparam int BIT_INVERT = 14;
  localparam int BIT_ERASE_PAUSE = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // bits a status write may change (not 15, 10, 1, 0)
  localparam logic [15:0] STATUS_WRITE_MASK = 16'h7BFC;
  localparam logic [15:0] STATUS_LOCK_MASK = 16'h3800;
  localparam logic [4:0] RANGE_NONE = 5'h00;
  // busy time of a self-timed operation
  localparam int BUSY_TIME_US = 100;
  localparam int CLOCK_MHZ = 10;
  localparam int BUSY_CYCLES = BUSY_TIME_US * CLOCK_MHZ;
  // host register offsets
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_BUSY = 0;
  localparam int HALF_PERIOD_CYCLES = 4;
endpackage

// file: design/fwlsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fwlsp_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  modport device (input cs_n, input sclk, input sdi, output sdo, output sdo_oe_n);
  modport host (output cs_n, output sclk, output sdi, input sdo, input sdo_oe_n);
endinterface
`default_nettype wire

// file: design/fwlsp_device.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fwlsp_device #(
  parameter int BUSY_LEN = fwlsp_pkg::BUSY_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // serial link
  fwlsp_link_if.device link,
  // pins and array side
  input wire logic i_protect_pin,
  input wire logic i_power_cycle,
  output logic o_quad_lines,
  output logic [4:0] o_protect_range,
  output logic o_protect_invert,
  output logic o_busy,
  output logic o_write_latch,
  output logic o_start_op,
  output logic [7:0] o_start_opcode,
  output logic o_chip_clear_blocked
);
  import fwlsp_pkg::*;

  initial begin
    if (BUSY_LEN < 1 || BUSY_LEN > 65535) $error("BUSY_LEN out of range");
  end

  // link synchronisers
  logic [1:0] cs_sync_r, sclk_sync_r, sdi_sync_r;
  logic [1:0] protect_sync_r;
  logic sclk_prev_r, cs_prev_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      protect_sync_r <= 2'h0;
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[0], link.cs_n};
      sclk_sync_r <= {sclk_sync_r[0], link.sclk};
      sdi_sync_r <= {sdi_sync_r[0], link.sdi};
      protect_sync_r <= {protect_sync_r[0], i_protect_pin};
      sclk_prev_r <= sclk_sync_r[1];
      cs_prev_r <= cs_sync_r[1];
    end
  end
  logic cs_low, sclk_rise, sclk_fall, frame_end;
  assign cs_low = !cs_sync_r[1];
  assign sclk_rise = cs_low && sclk_sync_r[1] && !sclk_prev_r;
  assign sclk_fall = cs_low && !sclk_sync_r[1] && sclk_prev_r;
  assign frame_end = cs_sync_r[1] && !cs_prev_r;

  // command state
  logic [5:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] op_r, op_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic sdo_r, sdo_nxt, sdo_oe_n_r, sdo_oe_n_nxt;
  logic volatile_r, volatile_nxt;
  logic [15:0] busy_cnt_r, busy_cnt_nxt;
  logic start_r, start_nxt;
  logic [7:0] start_op_r, start_op_nxt;
  logic blocked_r, blocked_nxt;
  logic [15:0] write_word;

  function automatic logic is_status_read(input logic [7:0] op);
    return op == OP_STATUS_READ_LO || op == OP_STATUS_READ_HI;
  endfunction

  function automatic logic is_modify(input logic [7:0] op);
    return op == OP_PAGE_WRITE || op == OP_PAGE_CLEAR || op == OP_SMALL_CLEAR ||
      op == OP_BLOCK32_CLEAR || op == OP_BLOCK_CLEAR || op == OP_CHIP_CLEAR_A ||
      op == OP_CHIP_CLEAR_B;
  endfunction

  logic guard_locked;
  logic [15:0] status_view;
  always_comb begin
    // guard decode of the two protect bits
    case ({status_r[BIT_GUARD_HI], status_r[BIT_GUARD_LO]})
      2'h0: guard_locked = 1'b0;
      2'h1: guard_locked = !protect_sync_r[1];
      default: guard_locked = 1'b1;
    endcase
    status_view = status_r;
    status_view[BIT_BUSY] = busy_cnt_r != 16'h0000;
  end

  // command decode and status update
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    write_word = 16'h0000;
    op_nxt = op_r;
    data_nxt = data_r;
    status_nxt = status_r;
    shift_nxt = shift_r;
    sdo_nxt = sdo_r;
    sdo_oe_n_nxt = sdo_oe_n_r;
    volatile_nxt = volatile_r;
    busy_cnt_nxt = (busy_cnt_r != 16'h0000) ? busy_cnt_r - 16'h0001 : busy_cnt_r;
    start_nxt = 1'b0;
    start_op_nxt = start_op_r;
    blocked_nxt = blocked_r;
    if (busy_cnt_r == 16'h0001 && start_op_r != OP_SUSPEND) begin
      status_nxt[BIT_LATCH] = 1'b0;
    end
    if (sclk_rise) begin
      if (bit_cnt_r < 6'd8) begin
        op_nxt = {op_r[6:0], sdi_sync_r[1]};
      end else begin
        data_nxt = {data_r[14:0], sdi_sync_r[1]};
      end
      if (bit_cnt_r != 6'd63) begin
        bit_cnt_nxt = bit_cnt_r + 6'd1;
      end
      if (bit_cnt_r == 6'd7 && is_status_read({op_r[6:0], sdi_sync_r[1]})) begin
        shift_nxt = ({op_r[6:0], sdi_sync_r[1]} == OP_STATUS_READ_HI) ?
          {status_view[15:8], status_view[15:8]} : {status_view[7:0], status_view[7:0]};
      end
    end
    if (sclk_fall && bit_cnt_r >= 6'd8 && is_status_read(op_r)) begin
      sdo_nxt = shift_r[15];
      sdo_oe_n_nxt = 1'b0;
      shift_nxt = {shift_r[14:0], shift_r[15]};
    end
    if (frame_end) begin
      bit_cnt_nxt = 6'd0;
      sdo_oe_n_nxt = 1'b1;
      if (bit_cnt_r[2:0] == 3'd0 && bit_cnt_r != 6'd0) begin
        case (op_r)
          OP_WRITE_ALLOW: status_nxt[BIT_LATCH] = 1'b1;
          OP_WRITE_FORBID: status_nxt[BIT_LATCH] = 1'b0;
          OP_VOLATILE_ALLOW: volatile_nxt = 1'b1;
          OP_SUSPEND: begin
            if (busy_cnt_r != 16'h0000 && is_modify(start_op_r)) begin
              if (start_op_r == OP_PAGE_WRITE) status_nxt[BIT_PROG_PAUSE] = 1'b1;
              else status_nxt[BIT_ERASE_PAUSE] = 1'b1;
              busy_cnt_nxt = 16'h0000;
            end
          end
          OP_RESUME_A, OP_RESUME_B: begin
            status_nxt[BIT_PROG_PAUSE] = 1'b0;
            status_nxt[BIT_ERASE_PAUSE] = 1'b0;
          end
          OP_RESET: begin
            status_nxt[BIT_LATCH] = 1'b0;
            volatile_nxt = 1'b0;
          end
          OP_STATUS_WRITE, OP_STATUS_WRITE_HI: begin
            if ((status_r[BIT_LATCH] || volatile_r) && !guard_locked && busy_cnt_r == 16'h0000 &&
                (bit_cnt_r == 6'd16 || bit_cnt_r == 6'd24)) begin
              write_word = (bit_cnt_r == 6'd16) ? {8'h00, data_r[7:0]} : {data_r[7:0], data_r[15:8]};
              if (op_r == OP_STATUS_WRITE_HI) begin
                write_word = {data_r[7:0], status_r[7:0]};
              end
              write_word = write_word | (status_r & STATUS_LOCK_MASK);
              status_nxt = (status_r & ~STATUS_WRITE_MASK) | (write_word & STATUS_WRITE_MASK);
              if (!volatile_r) begin
                busy_cnt_nxt = BUSY_LEN[15:0];
                start_op_nxt = op_r;
              end
              volatile_nxt = 1'b0;
            end
          end
          default: begin
            if (is_modify(op_r) && status_r[BIT_LATCH] && busy_cnt_r == 16'h0000) begin
              if ((op_r == OP_CHIP_CLEAR_A || op_r == OP_CHIP_CLEAR_B) &&
                  status_r[BIT_RANGE_LO +: 5] != RANGE_NONE) begin
                blocked_nxt = 1'b1;
              end else begin
                busy_cnt_nxt = BUSY_LEN[15:0];
                start_op_nxt = op_r;
                start_nxt = 1'b1; // the array checks the region
                blocked_nxt = 1'b0;
              end
            end
          end
        endcase
      end
    end
    if (i_power_cycle) begin
      status_nxt[BIT_LATCH] = 1'b0;
      status_nxt[BIT_PROG_PAUSE] = 1'b0;
      status_nxt[BIT_ERASE_PAUSE] = 1'b0;
      if (status_r[BIT_GUARD_HI] && !status_r[BIT_GUARD_LO]) begin
        status_nxt[BIT_GUARD_HI] = 1'b0;
      end
      volatile_nxt = 1'b0;
    end
  end

  // register all command state
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_r <= 6'd0;
      op_r <= 8'h00;
      data_r <= 16'h0000;
      status_r <= STATUS_RESET;
      shift_r <= 16'h0000;
      sdo_r <= 1'b0;
      sdo_oe_n_r <= 1'b1;
      volatile_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      start_r <= 1'b0;
      start_op_r <= 8'h00;
      blocked_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      op_r <= op_nxt;
      data_r <= data_nxt;
      status_r <= status_nxt;
      shift_r <= shift_nxt;
      sdo_r <= sdo_nxt;
      sdo_oe_n_r <= sdo_oe_n_nxt;
      volatile_r <= volatile_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      start_r <= start_nxt;
      start_op_r <= start_op_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  // registered outputs
  logic busy_out_r, quad_r, inv_r, latch_out_r;
  logic [4:0] range_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_out_r <= 1'b0;
      quad_r <= 1'b0;
      inv_r <= 1'b0;
      latch_out_r <= 1'b0;
      range_r <= 5'h00;
    end else begin
      busy_out_r <= busy_cnt_nxt != 16'h0000;
      quad_r <= status_nxt[BIT_QUAD];
      inv_r <= status_nxt[BIT_INVERT];
      latch_out_r <= status_nxt[BIT_LATCH];
      range_r <= status_nxt[BIT_RANGE_LO +: 5];
    end
  end
  assign link.sdo = sdo_r;
  assign link.sdo_oe_n = sdo_oe_n_r;
  assign o_quad_lines = quad_r;
  assign o_protect_range = range_r;
  assign o_protect_invert = inv_r;
  assign o_busy = busy_out_r;
  assign o_write_latch = latch_out_r;
  assign o_start_op = start_r;
  assign o_start_opcode = start_op_r;
  assign o_chip_clear_blocked = blocked_r;
endmodule
`default_nettype wire

// file: design/fwlsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module fwlsp_host #(
  parameter int HALF = fwlsp_pkg::HALF_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial link
  fwlsp_link_if.host link
);
  import fwlsp_pkg::*;

  initial begin
    // both syncs on the round trip need at least three cycles per level
    if (HALF < 3 || HALF > 255) $error("HALF out of range");
  end

  typedef enum logic [1:0] {
    FWLSP_IDLE = 2'b00,
    FWLSP_SHIFT = 2'b01,
    FWLSP_END = 2'b10
  } fwlsp_state_type;

  fwlsp_state_type state_r, state_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [23:0] data_r, data_nxt;
  logic [5:0] len_r, len_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic [7:0] result_r, result_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [7:0] div_r, div_nxt;
  logic cs_n_r, cs_n_nxt, sclk_r, sclk_nxt, sdi_r, sdi_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic [1:0] sdo_sync_r;
  logic access, wr;
  assign access = i_psel && i_penable && !pready_r;
  assign wr = access && i_pwrite;

  // apb, divider and shifter; write-allow goes out as an ordinary command
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    len_nxt = len_r;
    shift_nxt = shift_r;
    result_nxt = result_r;
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    cs_n_nxt = cs_n_r;
    sclk_nxt = sclk_r;
    sdi_nxt = sdi_r;
    pready_nxt = access;
    prdata_nxt = 32'h00000000;
    if (access && !i_pwrite) begin
      case (i_paddr)
        REG_COMMAND: prdata_nxt = {24'h000000, cmd_r};
        REG_DATA: prdata_nxt = {8'h00, data_r};
        REG_CONTROL: prdata_nxt = {31'h00000000, state_r != FWLSP_IDLE};
        REG_RESULT: prdata_nxt = {24'h000000, result_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    case (state_r)
      FWLSP_IDLE: begin
        if (wr && i_paddr == REG_COMMAND) cmd_nxt = i_pwdata[7:0];
        if (wr && i_paddr == REG_DATA) data_nxt = i_pwdata[23:0];
        if (wr && i_paddr == REG_CONTROL && i_pwdata[CTRL_START]) begin
          // bits 13:8 give total bit count, multiple of eight
          len_nxt = i_pwdata[13:8];
          shift_nxt = {cmd_r, data_r};
          cnt_nxt = 6'd0;
          div_nxt = 8'h00;
          cs_n_nxt = 1'b0;
          sclk_nxt = 1'b0;
          sdi_nxt = cmd_r[7];
          state_nxt = FWLSP_SHIFT;
        end
      end
      FWLSP_SHIFT: begin
        if (div_r == HALF[7:0] - 8'h01) begin
          div_nxt = 8'h00;
          sclk_nxt = !sclk_r;
          if (!sclk_r) begin
            // rising edge: device samples sdi
            cnt_nxt = cnt_r + 6'd1;
          end else begin
            // falling edge: take the bit that stood at the last rise, once through both syncs
            result_nxt = {result_r[6:0], sdo_sync_r[1]};
            shift_nxt = {shift_r[30:0], 1'b0};
            sdi_nxt = shift_r[30];
            if (cnt_r == len_r) state_nxt = FWLSP_END;
          end
        end else begin
          div_nxt = div_r + 8'h01;
        end
      end
      FWLSP_END: begin
        if (div_r == HALF[7:0] - 8'h01) begin
          cs_n_nxt = 1'b1; // host ends the frame
          div_nxt = 8'h00;
          state_nxt = FWLSP_IDLE;
        end else begin
          div_nxt = div_r + 8'h01;
        end
      end
      default: state_nxt = FWLSP_IDLE;
    endcase
  end

  // register host state
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= FWLSP_IDLE;
      cmd_r <= 8'h00;
      data_r <= 24'h000000;
      len_r <= 6'd8;
      shift_r <= 32'h00000000;
      result_r <= 8'h00;
      cnt_r <= 6'd0;
      div_r <= 8'h00;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sdi_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      sdo_sync_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      len_r <= len_nxt;
      shift_r <= shift_nxt;
      result_r <= result_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      cs_n_r <= cs_n_nxt;
      sclk_r <= sclk_nxt;
      sdi_r <= sdi_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      sdo_sync_r <= {sdo_sync_r[0], link.sdo};
    end
  end
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.sdi = sdi_r;
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = 1'b0;
endmodule
`default_nettype wire

// file: test/fwlsp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module fwlsp_link_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic sclk_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // count serial clock rises inside a frame
  always_comb begin
    cnt_nxt = cnt_r;
    if (cs_n) begin
      cnt_nxt = 6'h00;
    end else if (sclk && !sclk_r) begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_r <= 1'b0;
      cnt_r <= 6'h00;
    end else begin
      sclk_r <= sclk;
      cnt_r <= cnt_nxt;
    end
  end
  // each clock level lasts four samples
  sequence s_high;
    sclk [*4];
  endsequence
  sequence s_low;
    !sclk [*4];
  endsequence
  chk_oe_idle: assert property (cs_n [*6] |-> sdo_oe_n)
    else $error("output driven outside a frame");
  chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock not idle low");
  chk_sdi_hold: assert property (!cs_n && sclk && sclk_r |-> $stable(sdi))
    else $error("data in moved while clock high");
  chk_sdo_fall: assert property (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo) |-> !sclk)
    else $error("data out moved while clock high");
  chk_frame_bytes: assert property ($rose(cs_n) |-> cnt_r[2:0] == 3'h0)
    else $error("frame not whole bytes");
  chk_oe_after_op: assert property ($fell(sdo_oe_n) |-> !cs_n && cnt_r >= 6'h08)
    else $error("output driven before opcode done");
  chk_sclk_high: assert property ($rose(sclk) |-> s_high)
    else $error("clock high level wrong length");
  chk_sclk_low: assert property ($fell(sclk) && !cs_n |-> s_low)
    else $error("clock low level wrong length");
endmodule
`default_nettype wire

// file: test/flash_write_latch_status_protect_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_write_latch_status_protect_test;
  import fwlsp_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic i_protect_pin = 1'b0;
  logic i_power_cycle = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_quad_lines, o_protect_invert, o_busy, o_write_latch, o_start_op, o_chip_clear_blocked;
  logic [4:0] o_protect_range;
  logic [7:0] o_start_opcode;
  logic [31:0] rd_d;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0;
  integer seed = 32'hA873BFA5;
  fwlsp_link_if fwlsp_link_if_i ();
  fwlsp_host #(.HALF(4)) fwlsp_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .link(fwlsp_link_if_i));
  fwlsp_device #(.BUSY_LEN(400)) fwlsp_device_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .link(fwlsp_link_if_i),
    .i_protect_pin(i_protect_pin), .i_power_cycle(i_power_cycle), .o_quad_lines(o_quad_lines),
    .o_protect_range(o_protect_range), .o_protect_invert(o_protect_invert), .o_busy(o_busy),
    .o_write_latch(o_write_latch), .o_start_op(o_start_op), .o_start_opcode(o_start_opcode),
    .o_chip_clear_blocked(o_chip_clear_blocked));
  fwlsp_link_props fwlsp_link_props_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .cs_n(fwlsp_link_if_i.cs_n),
    .sclk(fwlsp_link_if_i.sclk), .sdi(fwlsp_link_if_i.sdi), .sdo(fwlsp_link_if_i.sdo),
    .sdo_oe_n(fwlsp_link_if_i.sdo_oe_n));
  // 10 MHz clock
  always #50 i_clock = ~i_clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one apb transfer; reads leave their expectation in the queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m);
    int n;
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd_d = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  // send one frame and wait for the host to finish it
  task automatic cmd(input logic [7:0] op, input logic [23:0] d, input logic [5:0] bits);
    apb(1'b1, REG_COMMAND, {24'h0, op}, 32'h0, 32'h0);
    apb(1'b1, REG_DATA, {8'h00, d}, 32'h0, 32'h0);
    apb(1'b1, REG_CONTROL, {18'h0, bits, 8'h01}, 32'h0, 32'h0);
    rd_d = 32'h1;
    for (int i = 0; i < 100 && rd_d[CTRL_BUSY]; i++) apb(1'b0, REG_CONTROL, 32'h0, 32'h0, 32'h0);
    repeat (4) @(posedge i_clock); // let the device close the frame
  endtask
  task automatic stat(input logic hi, input logic [7:0] e, input logic [7:0] m);
    cmd(hi ? OP_STATUS_READ_HI : OP_STATUS_READ_LO, 24'h0, 6'h10);
    apb(1'b0, REG_RESULT, 32'h0, {24'h0, e}, {24'h0, m});
  endtask
  task automatic idle();
    rd_d = 32'h1;
    for (int i = 0; i < 20 && rd_d[0]; i++) stat(1'b0, 8'h00, 8'h00);
  endtask
  task automatic wr_stat(input logic [7:0] op, input logic [23:0] d, input logic [5:0] bits);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    cmd(op, d, bits);
    idle();
  endtask
  task automatic power();
    i_power_cycle <= 1'b1;
    @(posedge i_clock);
    i_power_cycle <= 1'b0;
  endtask
  // compare answers, count started operations, cut hangs
  always @(negedge i_clock) begin
    cycles++;
    if (o_start_op === 1'b1) begin
      starts++;
    end
    if (o_pready === 1'b1 && !i_pwrite && exp_q.size() > 0) begin
      if (msk_q[0] != 32'h0) begin
        check(o_prdata & msk_q[0], exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    stat(1'b0, 8'h00, 8'hFF);
    stat(1'b1, 8'h00, 8'hFF);
    apb(1'b0, (8'($random(seed)) & 8'hFC) | 8'h10, 32'h0, 32'h0, 32'hFFFFFFFF);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    stat(1'b0, 8'h02, 8'hFF);
    check(32'(o_write_latch), 32'h1);
    cmd(OP_WRITE_FORBID, 24'h0, 6'h08);
    stat(1'b0, 8'h00, 8'hFF);
    cmd(OP_STATUS_WRITE, 24'($random(seed)), 6'h10);
    cmd(OP_PAGE_WRITE, 24'($random(seed)), 6'h20);
    stat(1'b0, 8'h00, 8'hFF);
    check(32'(starts), 32'h0);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    cmd(OP_STATUS_WRITE, 24'h0C0000, 6'h10);
    check(32'(o_busy), 32'h1);
    stat(1'b0, 8'h0F, 8'hFF);
    idle();
    stat(1'b0, 8'h0C, 8'hFF);
    check(32'(o_protect_range), 32'h3);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    cmd(OP_CHIP_CLEAR_A, 24'h0, 6'h08);
    check(32'(o_chip_clear_blocked), 32'h1);
    stat(1'b0, 8'h0C, 8'hFD);
    cmd(OP_WRITE_FORBID, 24'h0, 6'h08);
    cmd(OP_VOLATILE_ALLOW, 24'h0, 6'h08);
    cmd(OP_STATUS_WRITE, 24'h0, 6'h10);
    stat(1'b0, 8'h00, 8'hFF);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    cmd(OP_STATUS_WRITE, 24'h004A00, 6'h18);
    stat(1'b1, 8'h4A, 8'hFF);
    idle();
    check(32'(o_quad_lines), 32'h1);
    check(32'(o_protect_invert), 32'h1);
    wr_stat(OP_STATUS_WRITE_HI, 24'h0, 6'h10);
    stat(1'b1, 8'h08, 8'hFF);
    cmd(OP_WRITE_ALLOW, 24'h0, 6'h08);
    cmd(OP_SMALL_CLEAR, 24'h0, 6'h20);
    cmd(OP_SUSPEND, 24'h0, 6'h08);
    stat(1'b1, 8'h88, 8'hFF);
    check(32'(starts), 32'h1);
    check(32'(o_start_opcode), 32'(OP_SMALL_CLEAR));
    check(32'(o_busy), 32'h0);
    cmd(OP_RESUME_A, 24'h0, 6'h08);
    stat(1'b1, 8'h08, 8'hFF);
    idle();
    wr_stat(OP_STATUS_WRITE, 24'h800000, 6'h10);
    wr_stat(OP_STATUS_WRITE, 24'h840000, 6'h10);
    stat(1'b0, 8'h80, 8'hFD);
    i_protect_pin <= 1'b1;
    wr_stat(OP_STATUS_WRITE, 24'h000100, 6'h18);
    stat(1'b1, 8'h09, 8'hFF);
    wr_stat(OP_STATUS_WRITE_HI, 24'h0, 6'h10);
    stat(1'b1, 8'h09, 8'hFF);
    power();
    stat(1'b1, 8'h08, 8'hFF);
    check(32'(o_write_latch), 32'h0);
    wr_stat(OP_STATUS_WRITE, 24'h800100, 6'h18);
    power();
    stat(1'b1, 8'h09, 8'hFF);
    stat(1'b0, 8'h80, 8'hFD);
    conclude();
  end
endmodule
`default_nettype wire
